// ===== tcs_timer.sv
// Compare timer with one-pulse, slave sync, output clear and break
`timescale 1ns/10ps
module tcs_timer (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_clk_en,
  // Configuration
  input  wire tcs_pkg::tcs_cfg_type  i_cfg,
  // Control strobes
  input  wire logic                  i_start,
  input  wire logic                  i_flag_clear,
  input  wire logic                  i_output_enable_set,
  // External signals
  input  wire logic                  i_trigger,
  input  wire logic                  i_ocref_clr,
  input  wire logic                  i_break_input,
  // Status and outputs
  output logic [tcs_pkg::TCS_CW-1:0] o_counter_value,
  output logic                       o_counting,
  output logic                       o_direction_down,
  output logic                       o_compare_event,
  output logic                       o_compare_flag,
  output logic                       o_update_event,
  output logic                       o_trigger_out,
  output logic                       o_output,
  output logic                       o_output_enable
);
  import tcs_pkg::*;

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  tcs_state_type s;       // Registered state
  tcs_state_type next_s;  // Next state
  logic trig_edge;        // Rising edge of trigger
  logic act;              // Trigger as the counter sees it
  logic gate;             // Counting allowed this cycle
  logic match;            // Counter equals compare
  logic reset_type;       // Mode where trigger resets counter
  logic upd_raw;          // Overflow or underflow
  logic slave_rst;        // Counter reset by trigger

  // ----------------------------------------
  // Combinational decode of trigger and gate
  // ----------------------------------------
  always_comb begin
    trig_edge  = i_trigger & ~s.trig_q;
    // [RULE1] delay reaction
    act        = i_cfg.master_slave_delay ? s.trig_pend : trig_edge;
    reset_type = (i_cfg.slave_mode_select == TCS_SLV_RESET) ||
                 (i_cfg.slave_mode_select == TCS_SLV_RST_TRG) ||
                 (i_cfg.slave_mode_select == TCS_SLV_GAT_RST);
    slave_rst  = act & reset_type;
    gate       = s.counting & i_cfg.counter_enable &
                 ((i_cfg.slave_mode_select != TCS_SLV_GAT_RST) | i_trigger);
    // [RULE4] match on sampled compare
    match      = gate & (s.counter_value == s.cmp);
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    // Everything holds while the clock enable is low, pulses too
    next_s          = s;
    upd_raw         = 1'b0;
    if (i_clk_en) begin
      // Pulses last one enabled cycle
      next_s.event_p  = 1'b0;
      next_s.update_p = 1'b0;
      next_s.trgo     = 1'b0;
      // [RULE13] sample each cycle
      next_s.cmp       = i_cfg.compare_value;
      next_s.per       = i_cfg.period_value;
      next_s.trig_q    = i_trigger;
      next_s.trig_pend = trig_edge & i_cfg.master_slave_delay;
      // Slaves see the edge one cycle later through this output
      next_s.trgo      = trig_edge;
      // Counter advance
      if (gate) begin
        if (!i_cfg.center_aligned) begin
          // [RULE5] period then zero
          if (s.counter_value >= s.per) begin
            next_s.counter_value = TCS_CNT_RST;
            upd_raw              = 1'b1;
          end else begin
            next_s.counter_value = s.counter_value + 1'b1;
          end
          next_s.dir = TCS_DIR_UP;
        end else begin
          case (s.dir)
            TCS_DIR_UP: begin
              // [RULE6] crest turn
              if (s.counter_value >= s.per) begin
                next_s.dir           = TCS_DIR_DOWN;
                next_s.counter_value = (s.per == TCS_CNT_RST) ? TCS_CNT_RST : s.per - 1'b1;
                upd_raw              = 1'b1;
              end else begin
                next_s.counter_value = s.counter_value + 1'b1;
              end
            end
            TCS_DIR_DOWN: begin
              // [RULE7] valley turn
              if (s.counter_value == TCS_CNT_RST) begin
                next_s.dir           = TCS_DIR_UP;
                next_s.counter_value = (s.per == TCS_CNT_RST) ? TCS_CNT_RST : TCS_CNT_RST + 1'b1;
                upd_raw              = 1'b1;
              end else begin
                next_s.counter_value = s.counter_value - 1'b1;
              end
            end
            default: begin
              next_s.dir = TCS_DIR_UP;
            end
          endcase
        end
      end
      // Repetition counter filters update events
      if (upd_raw) begin
        if (s.rep == TCS_REP_RST) begin
          next_s.update_p = 1'b1;
          next_s.rep      = i_cfg.repetition_count_reg;
        end else begin
          next_s.rep = s.rep - 1'b1;
        end
      end
      // One-pulse stops the counter at the update event
      if (next_s.update_p && i_cfg.one_pulse_enable) begin
        next_s.counting = 1'b0;
      end
      // Software start and stop
      if (i_start) begin
        next_s.counting = 1'b1;
      end
      if (!i_cfg.counter_enable) begin
        next_s.counting = 1'b0;
      end
      // [RULE2] trigger restart wins
      if (slave_rst && i_cfg.counter_enable) begin
        next_s.counter_value = TCS_CNT_RST;
        next_s.dir           = TCS_DIR_UP;
        next_s.rep           = i_cfg.repetition_count_reg;
        if (i_cfg.slave_mode_select == TCS_SLV_RST_TRG) begin
          next_s.counting = 1'b1;
        end
      end
      // [RULE8] toggle per event
      if (match) begin
        next_s.event_p = 1'b1;
      end
      case (i_cfg.output_mode)
        TCS_OC_TOGGLE: begin
          if (match) begin
            next_s.ocref = ~s.ocref;
          end
        end
        TCS_OC_PWM: begin
          next_s.ocref = s.counter_value < s.cmp;
        end
        default: begin
          next_s.ocref = s.ocref;
        end
      endcase
      // [RULE9] flag, set beats clear
      if (i_flag_clear) begin
        next_s.flag = 1'b0;
      end
      if (match) begin
        next_s.flag = 1'b1;
      end
      // [RULE11] release on update or slave reset
      if (next_s.update_p || slave_rst) begin
        next_s.clr_latch = 1'b0;
      end
      // [RULE10] clear latch in any slave mode
      if (i_ocref_clr && i_cfg.clear_enable) begin
        next_s.clr_latch = 1'b1;
      end
      // Main output enable: software or automatic re-enable
      if (i_output_enable_set || (i_cfg.automatic_output_enable && next_s.update_p)) begin
        next_s.moe = 1'b1;
      end
      // [RULE12] break forces output off
      if (i_break_input) begin
        next_s.moe = 1'b0;
      end
      next_s.out = next_s.ocref & ~next_s.clr_latch & next_s.moe;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s               <= '0;
      s.counter_value <= TCS_CNT_RST;
      s.dir           <= TCS_DIR_UP;
      s.rep           <= TCS_REP_RST;
      s.cmp           <= TCS_CMP_RST;
      s.per           <= TCS_PER_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs straight from flip-flops
  // ----------------------------------------
  assign o_counter_value  = s.counter_value;
  assign o_counting       = s.counting;
  assign o_direction_down = (s.dir == TCS_DIR_DOWN);
  assign o_compare_event  = s.event_p;
  assign o_compare_flag   = s.flag;
  assign o_update_event   = s.update_p;
  assign o_trigger_out    = s.trgo;
  assign o_output         = s.out;
  assign o_output_enable  = s.moe;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  chk_match_event: assert property ( // RULE4
    i_clk_en && match |=> o_compare_event && o_compare_flag)
    else $error("compare match gave no event");
  chk_sample_cmp: assert property ( // RULE13
    i_clk_en |=> s.cmp == $past(i_cfg.compare_value) && s.per == $past(i_cfg.period_value))
    else $error("compare or period not sampled");
  chk_toggle_out: assert property ( // RULE8
    i_clk_en && match && i_cfg.output_mode == TCS_OC_TOGGLE |=> s.ocref != $past(s.ocref))
    else $error("toggle missed on match");
  chk_delay_hold: assert property ( // RULE1
    i_clk_en && trig_edge && i_cfg.master_slave_delay && !s.trig_pend |=> s.trig_pend && o_trigger_out)
    else $error("delayed trigger not held");
  chk_delay_start: assert property ( // RULE2
    i_clk_en && s.trig_pend && i_cfg.master_slave_delay && i_cfg.counter_enable &&
    i_cfg.slave_mode_select == TCS_SLV_RST_TRG
    |=> o_counting && o_counter_value == TCS_CNT_RST)
    else $error("delayed trigger did not restart");
  chk_opm_stop: assert property ( // RULE2
    i_clk_en && next_s.update_p && i_cfg.one_pulse_enable && !slave_rst && !i_start |=> !o_counting)
    else $error("one-pulse did not stop");
  chk_clear_release: assert property ( // RULE11
    i_clk_en && slave_rst && !i_ocref_clr |=> !s.clr_latch)
    else $error("slave reset kept output clear");
  chk_break_off: assert property ( // RULE12
    i_clk_en && i_break_input |=> !o_output_enable && !o_output)
    else $error("break did not clear output");
  chk_flag_set: assert property ( // RULE9
    i_clk_en && match && i_flag_clear |=> o_compare_flag)
    else $error("flag clear beat event");

  // ----------------------------------------
  // Counter shape, clear, forwarding and freeze checks
  // ----------------------------------------
  // [RULE5] edge-mode wrap to zero
  chk_edge_wrap: assert property ( // RULE5
    i_clk_en && gate && !i_cfg.center_aligned && s.counter_value >= s.per
    |=> o_counter_value == TCS_CNT_RST)
    else $error("edge count did not wrap");
  // [RULE6] crest turns downward
  chk_crest_turn: assert property ( // RULE6
    i_clk_en && gate && i_cfg.center_aligned && s.dir == TCS_DIR_UP &&
    s.counter_value >= s.per && !slave_rst
    |=> o_direction_down)
    else $error("crest did not turn down");
  // [RULE7] valley turns upward
  chk_valley_turn: assert property ( // RULE7
    i_clk_en && gate && i_cfg.center_aligned && s.dir == TCS_DIR_DOWN &&
    s.counter_value == TCS_CNT_RST
    |=> !o_direction_down)
    else $error("valley did not turn up");
  // [RULE10] clear input holds output low
  chk_clear_low: assert property ( // RULE10
    i_clk_en && i_ocref_clr && i_cfg.clear_enable |=> !o_output)
    else $error("output clear ignored");
  // [RULE9] flag clear without event
  chk_flag_clear: assert property ( // RULE9
    i_clk_en && i_flag_clear && !match |=> !o_compare_flag)
    else $error("flag not cleared");
  // [RULE1] trigger forwarded to slaves
  chk_trig_fwd: assert property ( // RULE1
    i_clk_en && trig_edge |=> o_trigger_out)
    else $error("trigger not forwarded");
  // [RULE13] frozen while enable is low
  chk_freeze: assert property ( // RULE13
    !i_clk_en |=> $stable(o_counter_value) && $stable(o_output) && $stable(o_compare_event))
    else $error("state moved while frozen");

  // Main scenarios worth seeing
  cov_back_to_back: cover property (o_compare_event ##1 o_compare_event);
  cov_center_pair: cover property (i_cfg.center_aligned && o_compare_event ##1 o_compare_event);
  cov_delayed_restart: cover property (trig_edge && s.counter_value == s.per && i_cfg.one_pulse_enable &&
                                       i_cfg.master_slave_delay);
  cov_break: cover property (i_break_input ##1 !o_output_enable);
  cov_clear_release: cover property (s.clr_latch ##1 !s.clr_latch);

endmodule

// ===== tcs_pkg.sv
// Constants, modes and state record for the compare timer with slave sync
// Notes on behaviour
// [RULE1] Delay bit postpones own trigger reaction one cycle
// [RULE2] One-pulse retriggers even at period value
// [RULE3] Software keeps delay bit clear unless needed
// [RULE4] Every counter-compare match raises an event
// [RULE5] Edge mode: period then zero both fire
// [RULE6] Center crest: period-1 then period both fire
// [RULE7] Center valley: one then zero both fire
// [RULE8] Toggle mode inverts output on each event
// [RULE9] Every center-mode event sets compare flag
// [RULE10] Output clear works in reset-type slave modes
// [RULE11] Slave reset releases output clear, no lost cycle
// [RULE12] Break with automatic enable clears output
// [RULE13] Compare and period sampled every counter cycle
package tcs_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int TCS_CW = 16;  // Counter width
  localparam int TCS_RW = 8;   // Repetition counter width

  // ----------------------------------------
  // Slave mode selections
  // ----------------------------------------
  localparam logic [3:0] TCS_SLV_OFF     = 4'h0;  // Internal clock only
  localparam logic [3:0] TCS_SLV_RESET   = 4'h4;  // Trigger edge resets counter
  localparam logic [3:0] TCS_SLV_RST_TRG = 4'h8;  // Trigger edge resets and starts
  localparam logic [3:0] TCS_SLV_GAT_RST = 4'h9;  // Level gates, edge resets

  // ----------------------------------------
  // Output compare modes
  // ----------------------------------------
  localparam logic [1:0] TCS_OC_FROZEN = 2'h0;  // Reference holds
  localparam logic [1:0] TCS_OC_TOGGLE = 2'h1;  // Reference inverts on match
  localparam logic [1:0] TCS_OC_PWM    = 2'h2;  // Active while counter below compare

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [TCS_CW-1:0] TCS_CNT_RST = 16'h0000;  // Counter
  localparam logic [TCS_CW-1:0] TCS_PER_RST = 16'hFFFF;  // Sampled period
  localparam logic [TCS_CW-1:0] TCS_CMP_RST = 16'h0000;  // Sampled compare
  localparam logic [TCS_RW-1:0] TCS_REP_RST = 8'h00;     // Repetition counter

  // ----------------------------------------
  // Counting direction, one-hot
  // ----------------------------------------
  typedef enum logic [1:0] {
    TCS_DIR_UP   = 2'b01,
    TCS_DIR_DOWN = 2'b10
  } tcs_dir_type;

  // ----------------------------------------
  // Configuration carried as one record
  // ----------------------------------------
  typedef struct packed {
    logic              counter_enable;           // Counter may run
    logic              one_pulse_enable;         // Stop at update event
    logic [3:0]        slave_mode_select;        // Slave mode
    logic              master_slave_delay;       // Delay own trigger reaction
    logic              center_aligned;           // Up-down counting
    logic [1:0]        output_mode;              // Compare output mode
    logic              clear_enable;             // Honour output clear input
    logic              automatic_output_enable;  // Re-enable output at update
    logic [TCS_CW-1:0] period_value;             // Period
    logic [TCS_CW-1:0] compare_value;            // Compare
    logic [TCS_RW-1:0] repetition_count_reg;     // Repetition reload
  } tcs_cfg_type;

  // ----------------------------------------
  // Whole state of the timer
  // ----------------------------------------
  typedef struct packed {
    logic [TCS_CW-1:0] counter_value;  // Running counter
    tcs_dir_type       dir;            // Direction
    logic [TCS_RW-1:0] rep;            // Repetition down-counter
    logic [TCS_CW-1:0] cmp;            // Sampled compare
    logic [TCS_CW-1:0] per;            // Sampled period
    logic              counting;       // Counter running
    logic              trig_q;         // Previous trigger level
    logic              trig_pend;      // Trigger edge held one cycle
    logic              ocref;          // Compare reference
    logic              clr_latch;      // Output held clear
    logic              moe;            // Main output enable
    logic              flag;           // Sticky compare flag
    logic              event_p;        // Compare event pulse
    logic              update_p;       // Update event pulse
    logic              trgo;           // Trigger out to slaves
    logic              out;            // Driven output
  } tcs_state_type;

endpackage

// ===== tcs_trig_model.sv
// Trigger source and cascaded slave timer model
`timescale 1ns/10ps
module tcs_trig_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Request and master pulse
  input  wire logic       i_fire,
  input  wire logic       i_trigger_out,
  // Trigger level and slave count
  output logic            o_trigger,
  output logic [7:0]      o_slave_count
);
  logic [1:0] hold;  // Trigger cycles left

  // ----------------------------------------
  // Trigger pulse and slave follower
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trigger     <= 1'b0;
      hold          <= 2'h0;
      o_slave_count <= 8'h00;
    end else begin
      // Request raises trigger for three cycles
      if (i_fire) begin
        o_trigger <= 1'b1;
        hold      <= 2'h2;
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end else begin
        o_trigger <= 1'b0;
      end
      if (i_trigger_out) begin
        o_slave_count <= o_slave_count + 8'h01;
      end
    end
  end
endmodule

// ===== tcs_timer_bench.sv
// Self-checking bench for the compare timer
`timescale 1ns/10ps
module tcs_timer_bench;
  import tcs_pkg::*;
  logic              clk;       // Timer clock
  logic              reset_n;   // Async reset
  logic              clk_en;    // Clock enable
  tcs_cfg_type       cfg;       // Configuration
  logic              start;     // Start strobe
  logic              flag_clr;  // Flag clear strobe
  logic              oe_set;    // Enable set strobe
  logic              clr;       // Output clear level
  logic              brk;       // Break level
  logic              fire;      // Trigger request
  logic              trig;      // Trigger level
  logic [7:0]        slave_cnt; // Slave trigger count
  logic [TCS_CW-1:0] cnt;       // Counter value
  logic              counting, dn, ev, flag, tout, out, oe, upd;
  int                errors;    // Mismatches
  int                compares;  // Comparisons
  int                n;         // Loop count

  // Free-running clock
  always #50 clk = ~clk;

  tcs_timer i_tcs_timer (
    .i_clk(clk), .i_reset_n(reset_n), .i_clk_en(clk_en), .i_cfg(cfg),
    .i_start(start), .i_flag_clear(flag_clr), .i_output_enable_set(oe_set),
    .i_trigger(trig), .i_ocref_clr(clr), .i_break_input(brk),
    .o_counter_value(cnt), .o_counting(counting), .o_direction_down(dn),
    .o_compare_event(ev), .o_compare_flag(flag), .o_update_event(upd),
    .o_trigger_out(tout), .o_output(out), .o_output_enable(oe));

  tcs_trig_model i_tcs_trig_model (
    .i_clk(clk), .i_reset_n(reset_n), .i_fire(fire), .i_trigger_out(tout),
    .o_trigger(trig), .o_slave_count(slave_cnt));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for a counter value and direction
  task automatic wait_cnt(input logic [TCS_CW-1:0] v, input logic d);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (!(cnt === v && dn === d) && i < 100);
    if (i >= 100) begin
      errors++;
      final_report();
    end
  endtask

  // Request one trigger; returns after the edge that samples it
  task automatic fire_trig();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Compare change between two matches in consecutive cycles
  task automatic pair(input logic ca, input logic [15:0] w, input logic d,
                      input logic [15:0] c1, input logic [15:0] c2);
    logic o0;
    @(posedge clk);
    cfg.center_aligned <= ca;
    cfg.compare_value <= c1;
    wait_cnt(w, d);
    @(posedge clk);
    cfg.compare_value <= c2;
    #1;
    o0 = out;
    @(posedge clk);
    flag_clr <= 1'b1;
    #1;
    check(ev, 1'b1);
    check(out, !o0);
    @(posedge clk);
    flag_clr <= 1'b0;
    #1;
    check(ev, 1'b1);
    check(out, o0);
    check(flag, 1'b1);
    @(posedge clk);
    #1;
    check(ev, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    {start, flag_clr, oe_set, clr, brk, fire} = 6'h00;
    errors = 0;
    compares = 0;
    cfg = '0;
    cfg.counter_enable = 1'b1;
    cfg.output_mode = TCS_OC_TOGGLE;
    cfg.period_value = 16'h0008;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check(cnt, TCS_CNT_RST);
    check({flag, oe, out}, 3'h0);
    @(posedge clk);
    start <= 1'b1;
    oe_set <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    oe_set <= 1'b0;
    pair(1'b0, 16'h0007, 1'b0, 16'h0008, 16'h0000);
    pair(1'b1, 16'h0006, 1'b0, 16'h0007, 16'h0008);
    pair(1'b1, 16'h0002, 1'b1, 16'h0001, 16'h0000);
    // One-pulse with reset plus trigger, delay off then on
    @(posedge clk);
    cfg.center_aligned <= 1'b0;
    cfg.one_pulse_enable <= 1'b1;
    cfg.slave_mode_select <= TCS_SLV_RST_TRG;
    cfg.compare_value <= 16'h0003;
    for (int d = 0; d < 2; d++) begin
      repeat (4) @(posedge clk);
      cfg.counter_enable <= 1'b0;
      cfg.master_slave_delay <= d[0];
      @(posedge clk);
      cfg.counter_enable <= 1'b1;
      fire_trig();
      check(counting, !d[0]);
      check(tout, 1'b1);
      @(posedge clk);
      #1;
      check(counting, 1'b1);
    end
    check(slave_cnt, 8'h02);
    // Delayed trigger acts while counter equals period
    wait_cnt(16'h0005, 1'b0);
    fire_trig();
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (ev === 1'b1) n++;
    end
    check(16'(n), 16'h0001);
    // Output clear released by slave reset
    @(posedge clk);
    cfg.one_pulse_enable <= 1'b0;
    cfg.master_slave_delay <= 1'b0;
    cfg.output_mode <= TCS_OC_PWM;
    cfg.compare_value <= 16'h0005;
    cfg.clear_enable <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      cfg.slave_mode_select <= m ? TCS_SLV_RST_TRG : TCS_SLV_RESET;
      wait_cnt(16'h0001, 1'b0);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      #1;
      check(out, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      check(out, 1'b1);
    end
    // Break clears output, update restores enable
    @(posedge clk);
    cfg.automatic_output_enable <= 1'b1;
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    #1;
    check({oe, out}, 2'b00);
    for (n = 0; n < 20 && oe !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check(oe, 1'b1);
    check(upd, 1'b1);
    // Clock enable low freezes the counter
    @(posedge clk);
    clk_en <= 1'b0;
    @(posedge clk);
    #1;
    n = int'(cnt);
    repeat (3) @(posedge clk);
    #1;
    check(cnt, 16'(n));
    final_report();
  end
endmodule
